// File: inc/fdh_pkg.sv
// ***********************************************************
// shared constants of the flash disk host pin interface
// ***********************************************************
package fdh_pkg;

	// clock and initialization timing
	localparam int FDH_CLK_MHZ   = 100;
	localparam int FDH_INIT_NS   = 2000;
	localparam int FDH_INIT_CYC  = (FDH_INIT_NS * FDH_CLK_MHZ + 999) / 1000;
	localparam int FDH_CNTW      = 12;

	// bus widths and window layout
	localparam int FDH_AW        = 13;
	localparam int FDH_DW        = 16;
	localparam int FDH_WORDS     = 16;
	localparam int FDH_IDXW      = 4;
	localparam int FDH_IDX_LSB   = 1;
	localparam int FDH_PART_BIT  = 3;
	localparam int FDH_SEL_HI    = 12;
	localparam int FDH_SEL_LO    = 11;
	localparam int FDH_SHARED_A0 = 0;

	// strap and pin encodings
	localparam logic [1:0]  FDH_CHIP1     = 2'h0;
	localparam logic [1:0]  FDH_CHIP2     = 2'h3;
	localparam logic        FDH_WIDE      = 1'h1;
	localparam logic        FDH_DPD_ON    = 1'h1;
	localparam logic [1:0]  FDH_LANES_ALL = 2'h3;
	localparam logic [1:0]  FDH_LANE_LO   = 2'h1;
	localparam logic [1:0]  FDH_LANE_HI   = 2'h2;
	localparam logic [15:0] FDH_MEM_RST   = 16'h0000;
	localparam logic [7:0]  FDH_BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {FDH_INIT, FDH_READY, FDH_SLEEP} fdh_state_e;
	typedef logic [FDH_IDXW-1:0] fdh_idx_t;

	// byte lanes touched by one access, for reads and writes alike
	function automatic logic [1:0] fdh_lanes(input logic wide, input logic a0);
		if (wide == FDH_WIDE) begin
			fdh_lanes = FDH_LANES_ALL;
		end else if (a0) begin
			fdh_lanes = FDH_LANE_HI;
		end else begin
			fdh_lanes = FDH_LANE_LO;
		end
	endfunction

endpackage

// File: inc/fdh_if.sv
`timescale 1ns/1ns
// ***********************************************************
// access path between pin logic and window storage
// ***********************************************************
interface fdh_if import fdh_pkg::*; ();
	logic              wr_en;
	fdh_idx_t          wr_idx;
	logic [1:0]        wr_lanes;
	logic [FDH_DW-1:0] wr_data;
	fdh_idx_t          rd_idx;
	logic [FDH_DW-1:0] rd_data;
	logic              lock_n;
	logic [1:0]        protect_sel;

	modport pins  (output wr_en, wr_idx, wr_lanes, wr_data, rd_idx, lock_n, protect_sel, input rd_data);
	modport store (input wr_en, wr_idx, wr_lanes, wr_data, rd_idx, lock_n, protect_sel, output rd_data);
endinterface

// File: rtl/fdh_store.sv
`timescale 1ns/1ns
// ***********************************************************
// window storage with hardware write protection
// ***********************************************************
module fdh_store import fdh_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// access path
	fdh_if.store     bus
);

	logic [FDH_DW-1:0] mem_r   [FDH_WORDS];
	logic [FDH_DW-1:0] mem_nxt [FDH_WORDS];
	logic              blocked;

	assign blocked = !bus.lock_n && bus.protect_sel[bus.wr_idx[FDH_PART_BIT]];

	// next contents, one lane at a time
	always_comb begin
		for (int i = 0; i < FDH_WORDS; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (bus.wr_en && !blocked) begin
			if (bus.wr_lanes[0]) begin
				mem_nxt[bus.wr_idx][7:0] = bus.wr_data[7:0];
			end
			if (bus.wr_lanes[1]) begin
				mem_nxt[bus.wr_idx][15:8] = bus.wr_data[15:8];
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < FDH_WORDS; i++) begin
				mem_r[i] <= FDH_MEM_RST;
			end
		end else begin
			for (int i = 0; i < FDH_WORDS; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	// reads are combinational; the pin logic registers them
	assign bus.rd_data = mem_r[bus.rd_idx];

endmodule // fdh_store

// File: rtl/fdh_top.sv
`timescale 1ns/1ns
// How it works
// - width strap high gives a 16-bit data bus, low gives 8-bit.
// - in 8-bit mode the shared ball is address bit zero.
// - in 16-bit mode the shared ball enters and leaves deep sleep.
// - in 8-bit mode the upper data byte is ignored and never driven.
// - address bits 12:11 must match the two-bit chip strap, 00 or 11.
// - busy is pulled low during initialization; host waits for release.
// - lock low blocks writes to partitions chosen for protection.
// - interrupt requests pull the open-drain interrupt pin low.
// - a pending DMA transfer pulls the open-drain request pin low.
// - a 13-bit address bus, bit zero shared with deep sleep.
module fdh_top import fdh_pkg::*; (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// host address and data bus
	input  wire logic [FDH_AW-1:0] host_addr,
	input  wire logic [FDH_DW-1:0] host_data_in,
	output logic      [FDH_DW-1:0] host_data_out,
	output logic      [1:0]        host_data_oe,
	// host strobes, active low
	input  wire logic              host_ce_n,
	input  wire logic              host_oe_n,
	input  wire logic              host_we_n,
	// configuration straps and lock
	input  wire logic              width_strap,
	input  wire logic [1:0]        chip_select_strap,
	input  wire logic              lock_n,
	// device side events and protection choice
	input  wire logic              irq_event,
	input  wire logic              dma_pending,
	input  wire logic [1:0]        protect_sel,
	// open-drain outputs
	output logic                   busy_n_out,
	output logic                   busy_n_oe,
	output logic                   irq_n_out,
	output logic                   irq_n_oe,
	output logic                   dma_request_n_out,
	output logic                   dma_request_n_oe,
	// status
	output logic                   deep_sleep_state
);

	// ***********************************************************
	// state and straps
	// ***********************************************************
	fdh_state_e          state_r,  state_nxt;
	logic [FDH_CNTW-1:0] cnt_r,    cnt_nxt;
	logic                wide_r,   wide_nxt;
	logic [1:0]          strap_r,  strap_nxt;
	logic                deep_sleep_input;

	assign deep_sleep_input = host_addr[FDH_SHARED_A0];

	// initialization, sleep entry and exit
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		wide_nxt  = wide_r;
		strap_nxt = strap_r;
		case (state_r)
			FDH_INIT: begin
				if (cnt_r == '0) begin
					wide_nxt  = width_strap;
					strap_nxt = chip_select_strap;
				end
				if (cnt_r == FDH_CNTW'(FDH_INIT_CYC - 1)) begin
					state_nxt = FDH_READY;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			FDH_READY: begin
				if (wide_r == FDH_WIDE && deep_sleep_input == FDH_DPD_ON) begin
					state_nxt = FDH_SLEEP;
				end
			end
			FDH_SLEEP: begin
				if (deep_sleep_input != FDH_DPD_ON) begin
					state_nxt = FDH_READY;
				end
			end
			default: begin
				state_nxt = FDH_INIT;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= FDH_INIT;
			cnt_r   <= '0;
			wide_r  <= FDH_WIDE;
			strap_r <= FDH_CHIP1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			wide_r  <= wide_nxt;
			strap_r <= strap_nxt;
		end
	end

	// ***********************************************************
	// host access
	// ***********************************************************
	fdh_if               acc_if ();
	logic                sel;
	logic [1:0]          lanes;
	logic                armed_r,  armed_nxt;
	fdh_idx_t            cap_idx_r, cap_idx_nxt;
	logic [1:0]          cap_ln_r, cap_ln_nxt;
	logic [FDH_DW-1:0]   cap_d_r,  cap_d_nxt;
	logic [FDH_DW-1:0]   dout_nxt;
	logic [1:0]          doe_nxt;

	assign sel = (state_r == FDH_READY) && !host_ce_n
		&& (host_addr[FDH_SEL_HI:FDH_SEL_LO] == strap_r);

	// bit zero picks the byte when narrow
	assign lanes = fdh_lanes(wide_r, host_addr[FDH_SHARED_A0]);

	// word index from address bits above bit zero
	assign acc_if.rd_idx      = host_addr[FDH_IDX_LSB +: FDH_IDXW];
	assign acc_if.wr_idx      = cap_idx_r;
	assign acc_if.wr_lanes    = cap_ln_r;
	assign acc_if.wr_data     = cap_d_r;
	assign acc_if.lock_n      = lock_n;
	assign acc_if.protect_sel = protect_sel;
	// commit on the trailing edge of write enable or chip enable
	assign acc_if.wr_en       = armed_r && (host_we_n || host_ce_n);

	// write capture and read drive
	always_comb begin
		armed_nxt   = armed_r;
		cap_idx_nxt = cap_idx_r;
		cap_ln_nxt  = cap_ln_r;
		cap_d_nxt   = cap_d_r;
		dout_nxt    = '0;
		doe_nxt     = '0;
		if (acc_if.wr_en) begin
			armed_nxt = 1'b0;
		end
		// data is taken late in the strobe, where it is settled
		if (sel && !host_we_n) begin
			armed_nxt   = 1'b1;
			cap_idx_nxt = acc_if.rd_idx;
			cap_ln_nxt  = lanes;
			if (wide_r == FDH_WIDE) begin
				cap_d_nxt = host_data_in;
			end else begin
				cap_d_nxt = {host_data_in[7:0], host_data_in[7:0]};
			end
		end else if (sel && !host_oe_n) begin
			if (wide_r == FDH_WIDE) begin
				dout_nxt = acc_if.rd_data;
				doe_nxt  = FDH_LANES_ALL;
			end else begin
				doe_nxt = FDH_LANE_LO;
				if (lanes == FDH_LANE_HI) begin
					dout_nxt = {FDH_BYTE_ZERO, acc_if.rd_data[15:8]};
				end else begin
					dout_nxt = {FDH_BYTE_ZERO, acc_if.rd_data[7:0]};
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			armed_r       <= 1'b0;
			cap_idx_r     <= '0;
			cap_ln_r      <= '0;
			cap_d_r       <= '0;
			host_data_out <= '0;
			host_data_oe  <= '0;
		end else begin
			armed_r       <= armed_nxt;
			cap_idx_r     <= cap_idx_nxt;
			cap_ln_r      <= cap_ln_nxt;
			cap_d_r       <= cap_d_nxt;
			host_data_out <= dout_nxt;
			host_data_oe  <= doe_nxt;
		end
	end

	fdh_store u_store (
		.clock (clock),
		.nrst  (nrst),
		.bus   (acc_if.store)
	);

	// ***********************************************************
	// open-drain outputs and status
	// ***********************************************************
	logic busy_oe_nxt, irq_oe_nxt, dma_oe_nxt, sleep_nxt;

	always_comb begin
		busy_oe_nxt = (state_nxt == FDH_INIT);
		irq_oe_nxt  = irq_event;
		dma_oe_nxt  = dma_pending;
		sleep_nxt   = (state_nxt == FDH_SLEEP);
	end

	// driven levels are always low; only the enables move
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_n_oe         <= 1'b1;
			irq_n_oe          <= 1'b0;
			dma_request_n_oe  <= 1'b0;
			deep_sleep_state  <= 1'b0;
			busy_n_out        <= 1'b0;
			irq_n_out         <= 1'b0;
			dma_request_n_out <= 1'b0;
		end else begin
			busy_n_oe         <= busy_oe_nxt;
			irq_n_oe          <= irq_oe_nxt;
			dma_request_n_oe  <= dma_oe_nxt;
			deep_sleep_state  <= sleep_nxt;
			busy_n_out        <= 1'b0;
			irq_n_out         <= 1'b0;
			dma_request_n_out <= 1'b0;
		end
	end

endmodule // fdh_top

// File: bench/fdh_top_checker.sv
`timescale 1ns/1ns
// ***
// pin level checks of the host port
// ***
module fdh_top_checker import fdh_pkg::*; (
	// clock and reset
	input wire logic		clock,
	input wire logic		nrst,
	// host bus
	input wire logic [12:0]	host_addr,
	input wire logic [15:0]	host_data_out,
	input wire logic [1:0]	host_data_oe,
	input wire logic		host_ce_n,
	input wire logic		host_oe_n,
	input wire logic		host_we_n,
	// straps and events
	input wire logic		width_strap,
	input wire logic [1:0]	chip_select_strap,
	input wire logic		irq_event,
	input wire logic		dma_pending,
	// open-drain pins and status
	input wire logic		busy_n_oe,
	input wire logic		busy_n_out,
	input wire logic		irq_n_out,
	input wire logic		irq_n_oe,
	input wire logic		dma_request_n_out,
	input wire logic		dma_request_n_oe,
	input wire logic		deep_sleep_state
);
	logic [7:0]	age_r;
	logic [7:0]	age_nxt;
	// edges since reset, saturating so it never wraps into the busy span
	always_comb age_nxt = (age_r == 8'hFF) ? age_r : age_r + 8'h01;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) age_r <= 8'h00;
		else age_r <= age_nxt;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// a read that the device must take
	sequence rd_req;
		!busy_n_oe && !deep_sleep_state && !host_ce_n && !host_oe_n && host_we_n
			&& host_addr[12:11] == chip_select_strap;
	endsequence
	sequence no_read;
		host_data_oe == 2'h0;
	endsequence
	a_busy_span: assert property (!busy_n_out && busy_n_oe == (age_r < FDH_INIT_CYC)) else $error("busy span wrong");
	a_busy_refuse: assert property (busy_n_oe |=> no_read) else $error("read taken while busy");
	a_read_lanes: assert property (rd_req |=> host_data_oe == (width_strap ? 2'h3 : 2'h1))
		else $error("read lanes wrong");
	a_read_ends: assert property ((host_ce_n || host_oe_n || !host_we_n) |=> no_read)
		else $error("drives when not read");
	a_id_refuse: assert property (host_addr[12:11] != chip_select_strap |=> no_read)
		else $error("answered other id");
	a_upper_quiet: assert property (!width_strap |-> !host_data_oe[1] && host_data_out[15:8] == 8'h00)
		else $error("upper byte used");
	a_sleep_enter: assert property (width_strap && !busy_n_oe && host_addr[0] |=> deep_sleep_state)
		else $error("no sleep entry");
	a_sleep_exit: assert property (deep_sleep_state && !host_addr[0] |=> !deep_sleep_state)
		else $error("no sleep exit");
	a_irq_follow: assert property (age_r != 8'h00 |-> !irq_n_out && irq_n_oe == $past(irq_event))
		else $error("irq pin wrong");
	a_dma_follow: assert property (age_r != 8'h00 |-> !dma_request_n_out && dma_request_n_oe == $past(dma_pending))
		else $error("dma pin wrong");
endmodule // fdh_top_checker

bind fdh_top fdh_top_checker u_chk (.*);

// File: bench/fdh_host_model.sv
`timescale 1ns/1ns
// ***
// host processor side of the port
// ***
module fdh_host_model import fdh_pkg::*; (
	// clock and busy wire
	input wire logic		clock,
	input wire logic		busy_pin,
	// host bus
	output logic [12:0]	addr,
	output logic [15:0]	data,
	output logic		ce_n,
	output logic		oe_n,
	output logic		we_n
);
	// idle bus, low address so no sleep request
	initial begin
		addr = 13'h0000;
		data = 16'h0000;
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
	end
	task automatic cycle(input logic [12:0] a, input logic [15:0] d, input logic wr);
		@(posedge clock);
		addr <= a;
		data <= d;
		ce_n <= 1'b0;
		oe_n <= wr;
		we_n <= !wr;
		@(posedge clock);
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		we_n <= 1'b1;
		data <= ~d; // released bus no longer shows the last value
	endtask
	task automatic wait_ready(output logic ok);
		for (int i = 0; i < 400 && busy_pin !== 1'b1; i++) @(posedge clock);
		ok = busy_pin === 1'b1;
	endtask
	task automatic sleep(input logic on);
		@(posedge clock);
		addr <= {12'h000, on};
	endtask
endmodule // fdh_host_model

// File: bench/test_flash_disk_host_pin_interface.sv
`timescale 1ns/1ns
// ***
// self-checking bench of the host port
// ***
module test_flash_disk_host_pin_interface import fdh_pkg::*;;
	logic			clock, nrst, host_ce_n, host_oe_n, host_we_n, width_strap, lock_n;
	logic			irq_event, dma_pending, busy_n_oe, deep_sleep_state, busy_pin;
	logic [1:0]		chip_select_strap, protect_sel, host_data_oe;
	logic [12:0]	host_addr;
	logic [15:0]	host_data_in, host_data_out, v;
	logic [15:0]	mem[16];
	logic [7:0]		b[32];
	logic [17:0]	exp_q[$];
	int				fails = 0;
	int				n_compared = 0;
	// open-drain busy with pull-up
	assign busy_pin = busy_n_oe ? 1'b0 : 1'b1;
	fdh_top dut (.clock, .nrst, .host_addr, .host_data_in, .host_data_out, .host_data_oe, .host_ce_n,
		.host_oe_n, .host_we_n, .width_strap, .chip_select_strap, .lock_n, .irq_event, .dma_pending,
		.protect_sel, .busy_n_out(), .busy_n_oe, .irq_n_out(), .irq_n_oe(), .dma_request_n_out(),
		.dma_request_n_oe(), .deep_sleep_state);
	fdh_host_model u_host (.clock, .busy_pin, .addr(host_addr), .data(host_data_in), .ce_n(host_ce_n),
		.oe_n(host_oe_n), .we_n(host_we_n));
	task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] want);
		n_compared++;
		if (seen !== want) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// reset with new straps; a read during busy must stay unanswered
	task automatic restart(input logic w, input logic [1:0] id);
		logic ok;
		nrst <= 1'b0;
		width_strap <= w;
		chip_select_strap <= id;
		foreach (mem[i]) mem[i] = 16'h0000;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		u_host.cycle({id, 11'h000}, 16'h0000, 1'b0);
		u_host.wait_ready(ok);
		chk("busy release", {17'h0, ok}, 18'h1);
	endtask
	// let the last answer land before a reset can swallow it
	task automatic drain();
		repeat (2) @(posedge clock);
		chk("queue drained", 18'(exp_q.size()), 18'h0);
	endtask
	task automatic rd(input logic [12:0] a, input logic [17:0] e);
		exp_q.push_back(e);
		u_host.cycle(a, 16'($urandom), 1'b0);
	endtask
	// each answer is matched against the oldest note
	always @(posedge clock) begin
		if (host_data_oe !== 2'h0) begin
			if (exp_q.size() == 0) chk("unasked read", {host_data_oe, host_data_out}, 18'h0);
			else chk("read data", {host_data_oe, host_data_out}, exp_q.pop_front());
		end
	end
	// device events toggle at random
	always @(posedge clock) begin
		irq_event <= 1'($urandom);
		dma_pending <= 1'($urandom);
	end
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
	initial begin
		void'($urandom(9868));
		{irq_event, dma_pending, lock_n, protect_sel} = 5'h02;
		restart(1'b1, 2'h0);
		for (int p = 0; p < 2; p++) begin
			lock_n <= p[0];
			for (int i = 0; i < 16; i++) begin
				v = 16'($urandom);
				u_host.cycle({8'h00, i[3:0], 1'b0}, v, 1'b1);
				if (p == 1 || i < 8) mem[i] = v;
			end
			for (int i = 0; i < 16; i++) rd({8'h00, i[3:0], 1'b0}, {2'h3, mem[i]});
		end
		u_host.cycle({2'h3, 11'h002}, 16'hFFFF, 1'b1);
		u_host.cycle({2'h3, 11'h002}, 16'h0000, 1'b0);
		rd(13'h0002, {2'h3, mem[1]});
		u_host.sleep(1'b1);
		u_host.cycle(13'h0001, 16'h0000, 1'b0);
		@(negedge clock);
		chk("sleep", {17'h0, deep_sleep_state}, 18'h1);
		u_host.sleep(1'b0);
		repeat (2) @(negedge clock);
		chk("awake", {17'h0, deep_sleep_state}, 18'h0);
		rd(13'h0000, {2'h3, mem[0]});
		drain();
		restart(1'b0, 2'h3);
		for (int i = 0; i < 32; i++) begin
			v = 16'($urandom);
			u_host.cycle({2'h3, 6'h00, i[4:0]}, v, 1'b1);
			b[i] = v[7:0];
		end
		for (int i = 0; i < 32; i++) rd({2'h3, 6'h00, i[4:0]}, {10'h100, b[i]});
		chk("narrow awake", {17'h0, deep_sleep_state}, 18'h0);
		drain();
		wrap_up();
	end
endmodule // test_flash_disk_host_pin_interface
